/* phy_bmc_consts.svh */
// Offsets, field positions, reset values and timing of the control register.
`ifndef PHY_BMC_CONSTS_SVH
`define PHY_BMC_CONSTS_SVH
`define BMC_OFFSET        5'h00
`define BMC_RESET_VALUE   16'h3100
`define BMC_BIT_RESET     15
`define BMC_BIT_LOOPBACK  14
`define BMC_BIT_SPEED     13
`define BMC_BIT_ANEG_EN   12
`define BMC_BIT_PWR_DOWN  11
`define BMC_BIT_ISOLATE   10
`define BMC_BIT_AN_RESTART 9
`define BMC_BIT_DUPLEX    8
`define BMC_BIT_COL_TEST  7
`define BMC_RSVD_MASK     16'h007F
`define BMC_CLK_NS        40
`define BMC_BIT_NS        10
`define BMC_COL_ON_BT     512
`define BMC_COL_OFF_BT    4
`define BMC_COL_OFF_CYC   ((`BMC_COL_OFF_BT * `BMC_BIT_NS) / `BMC_CLK_NS)
`define BMC_COL_ON_CYC    ((`BMC_COL_ON_BT * `BMC_BIT_NS) / `BMC_CLK_NS)
`define BMC_STRAP_WAIT    3'h4
`endif

/* phy_bmc_pkg.sv */
// Types shared by the control register logic.
`default_nettype none
package phy_bmc_pkg;
  typedef enum logic [0:0] {
    ST_STRAP = 1'b0,
    ST_RUN   = 1'b1
  } phase_e;
endpackage
`default_nettype wire

/* pin_sync.sv */
// Three-stage synchroniser that reports a change once stages two and three agree.
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] level;
  } sync_s;

  sync_s st;
  sync_s next_st;

  if (W < 1) begin : g_chk
    $error("W must be at least 1");
  end

  always_comb begin
    next_st    = st;
    next_st.s1 = pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < W; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.level[i] = st.s3[i];
      end
    end
  end

  always_ff @(posedge mclk) begin
    st <= next_st;
  end

  assign level = st.level;
endmodule
`default_nettype wire

/* phy_common_pinout_mode_mode_control.sv */
// Common_pinout_mode mode control register with loopback, collision test and strap logic.
// Notes on behaviour
// [R1] Loopback returns transmit data to receive lines.
// [R2] Software also programs self-test register for loopback.
// [R3] Speed bit picks 10 or 100 when forced.
// [R4] Common-pinout mode loads speed bit from strap.
// [R5] Negotiation enable loads from strap, resets enabled.
// [R6] Negotiation on ignores speed and duplex bits.
// [R7] Power-down bit stops all but register access; code blanks mii_rxd and mii_rx_dv only, not mii_col.
// [R8] Extended mode: low pin ORs into power-down.
// [R9] Isolate cuts MII, stops 50MHz clock output.
// [R10] Restart ignored while negotiation disabled.
// [R11] Restart reads one until negotiation starts.
// [R12] Clearing restart leaves running negotiation alone.
// [R13] Duplex bit picks half or full when forced.
// [R14] Collision test raises COL after transmit enable.
// [R15] Collision test drops COL after enable falls.
// [R16] Reserved bits read zero, ignore writes.
// [R17] Soft reset bit resets, clears when done.
// [R18] Register at offset zero, resets to 3100h.
`include "phy_bmc_consts.svh"
`default_nettype none
module phy_common_pinout_mode_mode_control
  import phy_bmc_pkg::*;
#(
  parameter int DATA_W = 4
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic [4:0]        reg_addr,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [15:0]       reg_wdata,
  output logic      [15:0]       reg_rdata,
  input  wire logic              common_pinout_mode,
  input  wire logic              strap_aneg_en,
  input  wire logic              strap_speed_100,
  input  wire logic              strap_full_duplex,
  input  wire logic              strap_isolate,
  input  wire logic              interrupt_powerdown_pin_n,
  input  wire logic              an_started,
  input  wire logic              an_speed_100,
  input  wire logic              an_full_duplex,
  input  wire logic              pcs_reset_done,
  input  wire logic [DATA_W-1:0] mii_txd,
  input  wire logic              mii_tx_en,
  input  wire logic [DATA_W-1:0] phy_rxd,
  input  wire logic              phy_rx_dv,
  input  wire logic              phy_col,
  output logic      [DATA_W-1:0] mii_rxd,
  output logic                   mii_rx_dv,
  output logic                   mii_col,
  output logic                   an_enable,
  output logic                   an_restart,
  output logic                   speed_100,
  output logic                   full_duplex,
  output logic                   power_down,
  output logic                   isolate,
  output logic                   clk50_enable,
  output logic                   pcs_reset
);
  localparam int COL_OFF_CYC = `BMC_COL_OFF_CYC < 1 ? 1 : `BMC_COL_OFF_CYC;

  if (DATA_W != 4 && DATA_W != 2) begin : g_chk
    $error("DATA_W must be 4 or 2");
  end

  typedef struct packed {
    phase_e      phase;
    logic [2:0]  wait_cnt;
    logic [3:0]  straps;
    logic [15:7] ctl;
    logic [15:0] rdata;
    logic [DATA_W-1:0] rxd;
    logic        rx_dv;
    logic        col;
    logic        restart;
  } state_s;

  state_s st;
  state_s next_st;
  logic [5:0] sync;
  logic       pin_low;

  pin_sync #(.W(6)) u_sync (
    .mclk  (mclk),
    .pin   ({common_pinout_mode, strap_aneg_en, strap_speed_100,
             strap_full_duplex, strap_isolate, interrupt_powerdown_pin_n}),
    .level (sync)
  );

  assign pin_low = ~sync[0] & ~sync[5];

  function automatic logic [15:7] defaults(input logic [3:0] s,
                                           input logic       common);
    logic [15:0] v;
    v = `BMC_RESET_VALUE;
    v[`BMC_BIT_ANEG_EN] = s[3]; // R5
    if (common) begin
      v[`BMC_BIT_SPEED]   = s[2]; // R4
      v[`BMC_BIT_DUPLEX]  = s[1]; // R13
      v[`BMC_BIT_ISOLATE] = s[0]; // R9
    end
    return v[15:7];
  endfunction

  always_comb begin
    logic wr0;
    wr0 = reg_wr && reg_addr == `BMC_OFFSET; // R18
    next_st = st;
    next_st.restart = 1'b0;
    case (st.phase)
      ST_STRAP: begin
        next_st.wait_cnt = st.wait_cnt + 3'h1;
        if (st.wait_cnt == `BMC_STRAP_WAIT) begin
          next_st.phase  = ST_RUN;
          next_st.straps = sync[4:1];
          next_st.ctl    = defaults(sync[4:1], sync[5]);
        end
      end
      ST_RUN: begin
        if (wr0) begin
          next_st.ctl[15:10] = reg_wdata[15:10];
          next_st.ctl[8:7]   = reg_wdata[8:7];
          if (!reg_wdata[`BMC_BIT_AN_RESTART]) begin
            next_st.ctl[`BMC_BIT_AN_RESTART] = 1'b0; // R12
          end else if (reg_wdata[`BMC_BIT_ANEG_EN]) begin
            next_st.ctl[`BMC_BIT_AN_RESTART] = 1'b1; // R11
            next_st.restart = 1'b1;
          end
          if (!reg_wdata[`BMC_BIT_RESET]) begin
            next_st.ctl[`BMC_BIT_RESET] = st.ctl[`BMC_BIT_RESET];
          end
        end
        if (an_started && !(wr0 && reg_wdata[`BMC_BIT_AN_RESTART])) begin
          next_st.ctl[`BMC_BIT_AN_RESTART] = 1'b0; // R11
        end
        if (!next_st.ctl[`BMC_BIT_ANEG_EN]) begin
          next_st.ctl[`BMC_BIT_AN_RESTART] = 1'b0; // R10
        end
        if (st.ctl[`BMC_BIT_RESET] && pcs_reset_done) begin
          next_st.ctl = defaults(st.straps, sync[5]); // R17
          next_st.restart = 1'b0;
        end
        if (pin_low) begin
          next_st.ctl[`BMC_BIT_PWR_DOWN] = 1'b1; // R8
        end
      end
      default: next_st.phase = ST_STRAP;
    endcase
    next_st.rdata = 16'h0000;
    if (reg_rd && reg_addr == `BMC_OFFSET) begin
      next_st.rdata = {st.ctl, 7'h00}; // R16
    end
    next_st.rxd   = st.ctl[`BMC_BIT_LOOPBACK] ? mii_txd   : phy_rxd; // R1
    next_st.rx_dv = st.ctl[`BMC_BIT_LOOPBACK] ? mii_tx_en : phy_rx_dv;
    if (st.ctl[`BMC_BIT_ISOLATE] || st.ctl[`BMC_BIT_PWR_DOWN]) begin
      next_st.rxd   = '0; // R9
      next_st.rx_dv = 1'b0;
    end
    next_st.col = st.ctl[`BMC_BIT_COL_TEST] ? mii_tx_en : phy_col; // R14 R15
    if (st.ctl[`BMC_BIT_ISOLATE]) begin
      next_st.col = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st       <= '0;
      st.ctl   <= 9'(`BMC_RESET_VALUE >> 7); // R18
      st.phase <= ST_STRAP;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata    = st.rdata;
  assign mii_rxd      = st.rxd;
  assign mii_rx_dv    = st.rx_dv;
  assign mii_col      = st.col;
  assign an_enable    = st.ctl[`BMC_BIT_ANEG_EN];
  assign an_restart   = st.restart;
  assign speed_100    = an_enable ? an_speed_100
                                  : st.ctl[`BMC_BIT_SPEED]; // R3 R6
  assign full_duplex  = an_enable ? an_full_duplex
                                  : st.ctl[`BMC_BIT_DUPLEX]; // R6 R13
  assign power_down   = st.ctl[`BMC_BIT_PWR_DOWN] | pin_low; // R7 R8
  assign isolate      = st.ctl[`BMC_BIT_ISOLATE];
  assign clk50_enable = ~st.ctl[`BMC_BIT_ISOLATE]; // R9
  assign pcs_reset    = st.ctl[`BMC_BIT_RESET]; // R17

  a_loop_data: assert property (@(posedge mclk) disable iff (rst) // R1
    st.ctl[14] && !isolate && !power_down |=> mii_rxd == $past(mii_txd))
    else $error("loopback data not returned");

  a_col_on: assert property (@(posedge mclk) disable iff (rst) // R14
    st.ctl[7] && !isolate && $rose(mii_tx_en) && mii_tx_en ##1
      st.ctl[7] |-> mii_col)
    else $error("collision test did not raise col");

  a_col_off: assert property (@(posedge mclk) disable iff (rst) // R15
    st.ctl[7] && !isolate && !mii_tx_en |-> ##COL_OFF_CYC !mii_col)
    else $error("collision test did not drop col");

  a_restart_gate: assert property (@(posedge mclk) disable iff (rst) // R10
    !an_enable |-> !st.ctl[9])
    else $error("restart set while negotiation off");

  a_restart_hold: assert property (@(posedge mclk) disable iff (rst) // R11
    st.ctl[9] && !an_started && an_enable && !pin_low &&
      !(reg_wr && reg_addr == 5'h00) && !(pcs_reset && pcs_reset_done)
      |=> st.ctl[9])
    else $error("restart cleared before start");

  a_restart_pulse: assert property (@(posedge mclk) disable iff (rst) // R11
    an_restart |-> st.ctl[9] && $past(reg_wr) && $past(reg_wdata[9]))
    else $error("restart pulse without request");

  a_rsvd_zero: assert property (@(posedge mclk) disable iff (rst) // R16
    reg_rdata[6:0] == 7'h00)
    else $error("reserved bits not zero");

  a_pin_pdown: assert property (@(posedge mclk) disable iff (rst) // R8
    pin_low && st.phase == ST_RUN |=> st.ctl[11] && power_down)
    else $error("pin did not set power down");

  a_forced_speed: assert property (@(posedge mclk) disable iff (rst) // R3
    !an_enable |-> speed_100 == st.ctl[13] && full_duplex == st.ctl[8])
    else $error("forced speed or duplex wrong");

  a_reset_hold: assert property (@(posedge mclk) disable iff (rst) // R17
    pcs_reset && !pcs_reset_done |=> pcs_reset)
    else $error("soft reset cleared early");
endmodule
`default_nettype wire

/* mgmt_model.sv */
// Management controller model that drives the parallel register port.
`default_nettype none
module mgmt_model (
  input  wire logic        mclk,
  output logic      [4:0]  reg_addr,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [15:0] reg_wdata,
  input  wire logic [15:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reg_addr = 5'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
  end
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

/* phy_common_pinout_mode_mode_control_bench.sv */
// Self-checking bench for the common_pinout_mode mode control register.
`default_nettype none
module phy_common_pinout_mode_mode_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst, cpm, s_an, s_sp, s_fd, s_iso, pd_n, an_st, an_sp;
  logic done, tx_en, wr, rd, rx_dv, col, an_en, an_rs, sp, fd, pd;
  logic iso, c50, pcs, an_fd, prv, pcol;
  logic [3:0] txd, rxd, prx;
  logic [4:0] addr;
  logic [15:0] wd, rdat, v;
  logic [7:0] lf;
  int num_errors, checks;
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  mgmt_model i_m (.mclk(mclk), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
    .reg_wdata(wd), .reg_rdata(rdat));
  phy_common_pinout_mode_mode_control i_dut (.mclk(mclk), .rst(rst), .reg_addr(addr),
    .reg_wr(wr), .reg_rd(rd), .reg_wdata(wd), .reg_rdata(rdat),
    .common_pinout_mode(cpm), .strap_aneg_en(s_an), .strap_speed_100(s_sp),
    .strap_full_duplex(s_fd), .strap_isolate(s_iso),
    .interrupt_powerdown_pin_n(pd_n), .an_started(an_st),
    .an_speed_100(an_sp), .an_full_duplex(an_fd), .pcs_reset_done(done),
    .mii_txd(txd), .mii_tx_en(tx_en), .phy_rxd(prx), .phy_rx_dv(prv),
    .phy_col(pcol), .mii_rxd(rxd), .mii_rx_dv(rx_dv), .mii_col(col),
    .an_enable(an_en), .an_restart(an_rs), .speed_100(sp),
    .full_duplex(fd), .power_down(pd), .isolate(iso),
    .clk50_enable(c50), .pcs_reset(pcs));
  task automatic boot;
    rst = 1'b1;
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    repeat (10) @(negedge mclk);
  endtask
  initial begin
    {cpm, s_sp, s_fd, s_iso, an_st, an_sp, done, tx_en, txd} = '0;
    {s_an, pd_n} = 2'h3;
    {an_fd, prv, pcol, prx} = 7'h00;
    num_errors = 0;
    checks = 0;
    lf = 8'h1A;
    boot();
    i_m.rd(5'h00, v);
    chk(v, 16'h3100);
    chk({15'h0, an_en}, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      i_m.wr(5'h00, {2'h0, i[1], 4'h1, i[0], 8'hFF});
      i_m.rd(5'h00, v);
      chk(v, {2'h0, i[1], 4'h0, i[0], 8'h80});
      chk({14'h0, sp, fd}, {14'h0, i[1], i[0]});
    end
    i_m.wr(5'h00, 16'h3100);
    an_sp = 1'b0;
    @(negedge mclk);
    chk({14'h0, sp, fd}, 16'h0000);
    $display("test forced modes done");
    i_m.wr(5'h00, 16'h1200);
    chk({15'h0, an_rs}, 16'h0001);
    i_m.rd(5'h00, v);
    chk(v, 16'h1200);
    an_st = 1'b1;
    @(negedge mclk);
    an_st = 1'b0;
    i_m.rd(5'h00, v);
    chk(v, 16'h1000);
    i_m.wr(5'h00, 16'h1200);
    i_m.wr(5'h00, 16'h1000);
    chk({15'h0, an_rs}, 16'h0000);
    i_m.rd(5'h00, v);
    chk(v, 16'h1000);
    $display("test restart done");
    i_m.wr(5'h16, 16'h0004);
    i_m.rd(5'h16, v);
    chk(v, 16'h0000);
    i_m.wr(5'h00, 16'h4000);
    for (int i = 0; i < 8; i++) begin
      lf = nxt(lf);
      tx_en = lf[7];
      txd = lf[3:0];
      @(negedge mclk);
      chk({11'h0, rx_dv, rxd}, {11'h0, lf[7], lf[3:0]});
    end
    tx_en = 1'b0;
    i_m.wr(5'h00, 16'h0080);
    tx_en = 1'b1;
    @(negedge mclk);
    chk({15'h0, col}, 16'h0001);
    tx_en = 1'b0;
    @(negedge mclk);
    chk({15'h0, col}, 16'h0000);
    {prv, prx, pcol} = 6'h3F;
    i_m.wr(5'h00, 16'h0400);
    @(negedge mclk);
    chk({14'h0, iso, c50}, 16'h0002);
    chk({10'h0, rx_dv, rxd, col}, 16'h0000);
    i_m.wr(5'h00, 16'h0000);
    @(negedge mclk);
    chk({10'h0, rx_dv, rxd, col}, 16'h003F);
    pd_n = 1'b0;
    repeat (6) @(negedge mclk);
    chk({15'h0, pd}, 16'h0001);
    chk({11'h0, rx_dv, rxd}, 16'h0000);
    pd_n = 1'b1;
    i_m.rd(5'h00, v);
    chk(v, 16'h0800);
    $display("test datapath done");
    i_m.wr(5'h00, 16'h8000);
    chk({15'h0, pcs}, 16'h0001);
    done = 1'b1;
    for (int i = 0; pcs !== 1'b0; i++) begin
      if (i > 20) begin
        num_errors++;
        results();
      end
      @(negedge mclk);
    end
    done = 1'b0;
    repeat (10) @(negedge mclk);
    i_m.rd(5'h00, v);
    chk(v, 16'h3100);
    {cpm, s_an, s_iso} = 3'h5;
    boot();
    i_m.rd(5'h00, v);
    chk(v, 16'h0400);
    $display("test straps done");
    results();
  end
endmodule
`default_nettype wire
